// >>> prot_device.sv
// sector protection control of the serial flash device end
// assumes the link comes from a host on another board (asynchronous pins)
// and that the array engine obeys req_ok before changing any content
`timescale 1ns/1ps
`default_nettype none
module prot_device #(
  parameter int GLITCH = prot_pkg::GLITCH_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  prot_link_if.device link,
  input wire logic req_valid,
  input wire prot_pkg::req_kind_t req_kind,
  input wire logic [4:0] req_sector,
  input wire logic req_sub,
  input wire logic [7:0] req_data,
  output logic req_done,
  output logic req_ok,
  output logic protect_on,
  output logic [7:0] status
);
  logic sck_f;
  logic cs_f;
  logic mosi_f;
  logic wp_f;
  logic sck_d;
  logic cs_d;
  logic [31:0] shift;
  logic [5:0] bits;
  logic sw_flag;
  logic [7:0] preg [prot_pkg::SECTORS];
  logic [31:0] next_shift;
  logic [5:0] next_bits;
  logic next_sw_flag;
  logic [7:0] next_preg [prot_pkg::SECTORS];
  logic next_req_done;
  logic next_req_ok;
  logic next_protect_on;
  logic [7:0] next_status;
  logic sck_rise;
  logic cs_rise;
  logic wp_low;
  logic in_force;
  logic marked;
  logic allowed;

  // link pins pass the synchroniser only
  pin_filter #(.STABLE(1), .RESET_LEVEL(1'b0)) u_sck (
    .pclk(pclk),
    .presetn(presetn),
    .din(link.sck),
    .dout(sck_f)
  );
  pin_filter #(.STABLE(1), .RESET_LEVEL(1'b1)) u_cs (
    .pclk(pclk),
    .presetn(presetn),
    .din(link.cs_n),
    .dout(cs_f)
  );
  pin_filter #(.STABLE(1), .RESET_LEVEL(1'b0)) u_mosi (
    .pclk(pclk),
    .presetn(presetn),
    .din(link.mosi),
    .dout(mosi_f)
  );
  // write-protect pin idles high and must hold a level to count
  pin_filter #(.STABLE(GLITCH), .RESET_LEVEL(1'b1)) u_wp (
    .pclk(pclk),
    .presetn(presetn),
    .din(link.wp_n),
    .dout(wp_f)
  );

  // is the addressed sector flagged for protection
  function automatic logic sector_marked(input logic [7:0] entry, input logic [4:0] sector,
      input logic sub);
    logic r;
    r = 1'b0;
    if (sector != 5'h00) begin
      r = (entry == prot_pkg::SECTOR_LOCKED);
    end else if (!sub) begin
      r = &entry[prot_pkg::SUB0A_HI:prot_pkg::SUB0A_LO];
    end else begin
      r = &entry[prot_pkg::SUB0B_HI:prot_pkg::SUB0B_LO];
    end
    return r;
  endfunction

  assign sck_rise = sck_f & ~sck_d;
  assign cs_rise = cs_f & ~cs_d;
  assign wp_low = ~wp_f;

  // command shifter, mode 0: bits taken on sck rise while selected
  always_comb begin
    next_shift = shift;
    next_bits = bits;
    if (cs_f) begin
      next_bits = 6'h00;
    end else if (sck_rise) begin
      next_shift = {shift[30:0], mosi_f};
      if (bits != prot_pkg::CMD_BITS + 6'h01) begin
        next_bits = bits + 6'h01;
      end
    end
  end

  // software flag acts only on a deselect after exactly 32 bits
  always_comb begin
    next_sw_flag = sw_flag;
    if (cs_rise && bits == prot_pkg::CMD_BITS) begin
      if (shift == prot_pkg::CMD_ENABLE_WORD) begin
        next_sw_flag = 1'b1;
      end else if (shift == prot_pkg::CMD_DISABLE_WORD && !wp_low) begin
        next_sw_flag = 1'b0;
      end
    end
  end

  // protection in force from either source
  assign in_force = sw_flag | wp_low;

  // request check against the protection register
  always_comb begin
    marked = sector_marked(preg[req_sector], req_sector, req_sub);
    allowed = 1'b1;
    next_preg = preg;
    case (req_kind)
      prot_pkg::REQ_ARRAY: begin
        allowed = !(in_force && marked);
      end
      prot_pkg::REQ_PREG_PROGRAM: begin
        allowed = !wp_low;
        if (req_valid && allowed) begin
          next_preg[req_sector] = req_data;
        end
      end
      prot_pkg::REQ_PREG_ERASE: begin
        allowed = !wp_low;
        if (req_valid && allowed) begin
          for (int i = 0; i < prot_pkg::SECTORS; i++) begin
            next_preg[i] = prot_pkg::PREG_ERASED;
          end
        end
      end
      default: begin
        allowed = 1'b0;
      end
    endcase
    next_req_done = req_valid;
    next_req_ok = req_valid & allowed;
  end

  // status byte
  always_comb begin
    next_protect_on = in_force;
    next_status = 8'h00;
    next_status[prot_pkg::STATUS_SW_BIT] = sw_flag;
    next_status[prot_pkg::STATUS_PROTECT_BIT] = in_force;
    next_status[prot_pkg::STATUS_PIN_BIT] = wp_low;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sck_d <= 1'b0;
      cs_d <= 1'b1;
      shift <= 32'h00000000;
      bits <= 6'h00;
    end else begin
      sck_d <= sck_f;
      cs_d <= cs_f;
      shift <= next_shift;
      bits <= next_bits;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_flag <= 1'b0;
    end else begin
      sw_flag <= next_sw_flag;
    end
  end

  // nonvolatile contents modelled as shipped at reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < prot_pkg::SECTORS; i++) begin
        preg[i] <= prot_pkg::PREG_RESET;
      end
    end else begin
      preg <= next_preg;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_done <= 1'b0;
      req_ok <= 1'b0;
      protect_on <= 1'b0;
      status <= 8'h00;
    end else begin
      req_done <= next_req_done;
      req_ok <= next_req_ok;
      protect_on <= next_protect_on;
      status <= next_status;
    end
  end
endmodule // prot_device
`default_nettype wire

// >>> prot_pkg.sv
// constants shared by the protection device end and the host end
// assumes a single 250 MHz pclk for both ends
package prot_pkg;
  localparam int CLK_MHZ = 250;
  // command opcode bytes, first to last
  localparam logic [7:0] OP_PREFIX0 = 8'h3D;
  localparam logic [7:0] OP_PREFIX1 = 8'h2A;
  localparam logic [7:0] OP_PREFIX2 = 8'h7F;
  localparam logic [7:0] OP_ENABLE = 8'hA9;
  localparam logic [7:0] OP_DISABLE = 8'h9A;
  localparam logic [31:0] CMD_ENABLE_WORD = {OP_PREFIX0, OP_PREFIX1, OP_PREFIX2, OP_ENABLE};
  localparam logic [31:0] CMD_DISABLE_WORD = {OP_PREFIX0, OP_PREFIX1, OP_PREFIX2, OP_DISABLE};
  localparam logic [5:0] CMD_BITS = 6'h20;
  // protection register layout
  localparam int SECTORS = 32;
  localparam logic [7:0] SECTOR_LOCKED = 8'hFF;
  localparam logic [7:0] PREG_ERASED = 8'hFF;
  localparam logic [7:0] PREG_RESET = 8'h00;
  localparam int SUB0A_HI = 7;
  localparam int SUB0A_LO = 6;
  localparam int SUB0B_HI = 5;
  localparam int SUB0B_LO = 4;
  // device status byte fields
  localparam int STATUS_SW_BIT = 0;
  localparam int STATUS_PROTECT_BIT = 1;
  localparam int STATUS_PIN_BIT = 2;
  // timing
  localparam int GLITCH_NS = 20;
  localparam int GLITCH_CYCLES = (GLITCH_NS * CLK_MHZ + 999) / 1000;
  localparam int PROTECT_ASSERT_DELAY_NS = 100;
  localparam int PROTECT_ASSERT_DELAY_CYCLES = PROTECT_ASSERT_DELAY_NS * CLK_MHZ / 1000;
  localparam int PROTECT_RELEASE_DELAY_NS = 100;
  localparam int PROTECT_RELEASE_DELAY_CYCLES = PROTECT_RELEASE_DELAY_NS * CLK_MHZ / 1000;
  localparam int SCK_HALF_NS = 16;
  localparam int SCK_HALF_CYCLES = (SCK_HALF_NS * CLK_MHZ + 999) / 1000;
  localparam int CS_GAP_NS = 40;
  localparam int CS_GAP_CYCLES = (CS_GAP_NS * CLK_MHZ + 999) / 1000;
  // host register map
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CMD = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam int CTRL_WP_BIT = 0;
  localparam int CMD_ENABLE_BIT = 0;
  localparam int CMD_DISABLE_BIT = 1;
  localparam int HSTAT_BUSY_BIT = 0;
  localparam int HSTAT_WP_BIT = 1;
  localparam logic CTRL_WP_RESET = 1'b0;
  typedef enum logic [1:0] {REQ_ARRAY, REQ_PREG_PROGRAM, REQ_PREG_ERASE} req_kind_t;
endpackage

// >>> prot_link_if.sv
// serial link between host and protection device, with the write-protect pin
// assumes the pin is pulled high when the host does not drive it
`timescale 1ns/1ps
`default_nettype none
interface prot_link_if;
  logic sck;
  logic cs_n;
  logic mosi;
  logic wp_drive;
  logic wp_oe_n;
  logic wp_n;
  // internal pull-up on the pin
  assign wp_n = wp_oe_n ? 1'b1 : wp_drive;
  modport device (input sck, input cs_n, input mosi, input wp_n);
  modport host (output sck, output cs_n, output mosi, output wp_drive, output wp_oe_n,
    input wp_n);
endinterface
`default_nettype wire

// >>> pin_filter.sv
// three-stage synchroniser with stability filter for one pin
// assumes din is asynchronous to pclk
`timescale 1ns/1ps
`default_nettype none
module pin_filter #(
  parameter int STABLE = 1,
  parameter logic RESET_LEVEL = 1'b1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic din,
  output logic dout
);
  logic s1;
  logic s2;
  logic s3;
  logic [7:0] cnt;
  logic next_dout;
  logic [7:0] next_cnt;

  always_comb begin
    next_dout = dout;
    next_cnt = 8'h00;
    if (s2 == s3 && s3 != dout) begin
      if (cnt >= 8'(STABLE - 1)) begin
        next_dout = s3;
      end else begin
        next_cnt = cnt + 8'h01;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1 <= RESET_LEVEL;
      s2 <= RESET_LEVEL;
      s3 <= RESET_LEVEL;
      dout <= RESET_LEVEL;
      cnt <= 8'h00;
    end else begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
      dout <= next_dout;
      cnt <= next_cnt;
    end
  end
endmodule // pin_filter
`default_nettype wire

// >>> prot_host.sv
// host end: APB register slave that sends protection commands and drives the pin
// assumes APB master on pclk; the device samples the link asynchronously
`timescale 1ns/1ps
`default_nettype none
module prot_host (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  prot_link_if.host link
);
  typedef enum logic [2:0] {H_IDLE, H_LOW, H_HIGH, H_TRAIL, H_GAP} hstate_t;
  hstate_t state;
  hstate_t next_state;
  logic ctrl_wp;
  logic next_ctrl_wp;
  logic [31:0] word;
  logic [31:0] next_word;
  logic [4:0] bitn;
  logic [4:0] next_bitn;
  logic [7:0] timer;
  logic [7:0] next_timer;
  logic next_sck;
  logic next_cs_n;
  logic next_mosi;
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;
  logic wr;
  logic go_en;
  logic go_dis;

  // write lands at the access edge with pready high
  assign wr = psel & penable & pready & pwrite;
  assign go_en = wr && paddr == prot_pkg::REG_CMD && pwdata[prot_pkg::CMD_ENABLE_BIT];
  assign go_dis = wr && paddr == prot_pkg::REG_CMD && pwdata[prot_pkg::CMD_DISABLE_BIT];

  always_comb begin
    next_pready = psel & ~penable;
    next_prdata = 32'h00000000;
    next_pslverr = 1'b0;
    next_ctrl_wp = ctrl_wp;
    if (psel && !penable) begin
      case (paddr)
        prot_pkg::REG_CTRL: next_prdata[prot_pkg::CTRL_WP_BIT] = ctrl_wp;
        prot_pkg::REG_CMD: next_prdata = 32'h00000000;
        prot_pkg::REG_STATUS: begin
          next_prdata[prot_pkg::HSTAT_BUSY_BIT] = (state != H_IDLE);
          next_prdata[prot_pkg::HSTAT_WP_BIT] = ~link.wp_n;
        end
        default: next_pslverr = 1'b1;
      endcase
    end else if (pready) begin
      next_prdata = prdata;
      next_pslverr = pslverr;
    end
    if (wr && paddr == prot_pkg::REG_CTRL) begin
      next_ctrl_wp = pwdata[prot_pkg::CTRL_WP_BIT];
    end
  end

  // serial sender, mode 0, msb first; orders while busy are dropped
  always_comb begin
    next_state = state;
    next_word = word;
    next_bitn = bitn;
    next_timer = timer + 8'h01;
    next_sck = link.sck;
    next_cs_n = link.cs_n;
    next_mosi = link.mosi;
    case (state)
      H_IDLE: begin
        next_timer = 8'h00;
        if (go_en || go_dis) begin
          next_word = go_en ? prot_pkg::CMD_ENABLE_WORD : prot_pkg::CMD_DISABLE_WORD;
          next_mosi = next_word[31];
          next_cs_n = 1'b0;
          next_bitn = 5'h00;
          next_state = H_LOW;
        end
      end
      H_LOW: begin
        if (timer == 8'(prot_pkg::SCK_HALF_CYCLES - 1)) begin
          next_timer = 8'h00;
          next_sck = 1'b1;
          next_state = H_HIGH;
        end
      end
      H_HIGH: begin
        if (timer == 8'(prot_pkg::SCK_HALF_CYCLES - 1)) begin
          next_timer = 8'h00;
          next_sck = 1'b0;
          if (bitn == 5'h1F) begin
            next_state = H_TRAIL;
          end else begin
            next_bitn = bitn + 5'h01;
            next_word = {word[30:0], 1'b0};
            next_mosi = word[30];
            next_state = H_LOW;
          end
        end
      end
      H_TRAIL: begin
        if (timer == 8'(prot_pkg::SCK_HALF_CYCLES - 1)) begin
          next_timer = 8'h00;
          next_cs_n = 1'b1;
          next_state = H_GAP;
        end
      end
      H_GAP: begin
        if (timer == 8'(prot_pkg::CS_GAP_CYCLES - 1)) begin
          next_state = H_IDLE;
        end
      end
      default: begin
        next_state = H_IDLE;
        next_cs_n = 1'b1;
        next_sck = 1'b0;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      ctrl_wp <= prot_pkg::CTRL_WP_RESET;
      link.wp_oe_n <= 1'b1;
      link.wp_drive <= 1'b0;
    end else begin
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
      ctrl_wp <= next_ctrl_wp;
      link.wp_oe_n <= ~next_ctrl_wp;
      link.wp_drive <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= H_IDLE;
      word <= 32'h00000000;
      bitn <= 5'h00;
      timer <= 8'h00;
      link.sck <= 1'b0;
      link.cs_n <= 1'b1;
      link.mosi <= 1'b0;
    end else begin
      state <= next_state;
      word <= next_word;
      bitn <= next_bitn;
      timer <= next_timer;
      link.sck <= next_sck;
      link.cs_n <= next_cs_n;
      link.mosi <= next_mosi;
    end
  end
endmodule // prot_host
`default_nettype wire

// >>> prot_link_asserts.sv
// checker for the serial link and the write-protect pin
// assumes it sits beside the link interface, all on pclk
`timescale 1ns/1ps
`default_nettype none
module prot_link_asserts (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic wp_drive,
  input wire logic wp_oe_n,
  input wire logic wp_n
);
  logic [5:0] rises;
  logic [5:0] next_rises;
  logic sck_q;
  logic next_sck_q;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // sck rises counted within one frame
  always_comb begin
    next_sck_q = sck;
    next_rises = rises;
    if (cs_n) begin
      next_rises = 6'h00;
    end else if (sck && !sck_q) begin
      next_rises = rises + 6'h01;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rises <= 6'h00;
      sck_q <= 1'b0;
    end else begin
      rises <= next_rises;
      sck_q <= next_sck_q;
    end
  end
  AST_SCK_IDLE: assert property (cs_n |-> !sck)
    else $error("clock moved outside a frame");
  AST_SCK_HIGH: assert property ($rose(sck) |-> sck[*4] ##1 !sck)
    else $error("clock high phase not four cycles");
  AST_SCK_LOW: assert property ($fell(sck) |-> !sck[*4])
    else $error("clock low phase too short");
  AST_MOSI_STABLE: assert property (sck |-> $stable(mosi))
    else $error("data moved while clock high");
  AST_FIRST_BIT: assert property ($fell(cs_n) |-> !sck[*4] ##1 sck)
    else $error("first clock not four cycles after select");
  AST_FRAME_32: assert property ($rose(cs_n) |-> rises == 6'h20)
    else $error("frame did not hold 32 bits");
  AST_CS_TRAIL: assert property ($fell(sck) && rises == 6'h20 |-> !cs_n[*3] ##[1:3] cs_n)
    else $error("select not raised after last bit");
  AST_CS_GAP: assert property ($rose(cs_n) |-> cs_n[*8])
    else $error("frames too close");
  AST_PIN_PULL: assert property (wp_oe_n |-> wp_n)
    else $error("released pin not high");
  AST_PIN_DRIVE: assert property (!wp_oe_n |-> !wp_drive && !wp_n)
    else $error("driven pin not low");
  cover property ($rose(cs_n) && rises == 6'h20);
  cover property ($fell(wp_n));
  cover property ($rose(wp_n));
endmodule // prot_link_asserts
`default_nettype wire

// >>> flash_sector_protection_ctrl_bench.sv
// bench: host and device ends joined by one link, driven over apb
// assumes prot_pkg, prot_link_if, both ends and the checker compiled first
`timescale 1ns/1ps
`default_nettype none
module flash_sector_protection_ctrl_bench;
  typedef struct {prot_pkg::req_kind_t k; logic [4:0] s; logic u; logic [7:0] d; logic ok;} row_t;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, er, seen;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic req_valid = 1'b0, req_sub = 1'b0, req_done, req_ok, protect_on;
  prot_pkg::req_kind_t req_kind = prot_pkg::REQ_ARRAY;
  logic [4:0] req_sector = 5'h00;
  logic [7:0] req_data = 8'h00, status;
  int n_mismatch = 0, total_checks = 0;
  row_t rows [7];
  prot_link_if link ();
  always #2 pclk = ~pclk;
  prot_host i_prot_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(link));
  prot_device i_prot_device (.pclk(pclk), .presetn(presetn), .link(link),
    .req_valid(req_valid), .req_kind(req_kind), .req_sector(req_sector), .req_sub(req_sub),
    .req_data(req_data), .req_done(req_done), .req_ok(req_ok), .protect_on(protect_on),
    .status(status));
  prot_link_asserts i_prot_link_asserts (.pclk(pclk), .presetn(presetn), .sck(link.sck),
    .cs_n(link.cs_n), .mosi(link.mosi), .wp_drive(link.wp_drive), .wp_oe_n(link.wp_oe_n),
    .wp_n(link.wp_n));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no cycle limit here: only the watchdog ends a hung transfer
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic cmd(input logic [31:0] c);
    apb(1'b1, prot_pkg::REG_CMD, c);
    do begin
      apb(1'b0, prot_pkg::REG_STATUS, 32'h0);
    end while (rd[prot_pkg::HSTAT_BUSY_BIT] !== 1'b0);
  endtask
  task automatic req(input row_t r);
    req_valid <= 1'b1;
    req_kind <= r.k;
    req_sector <= r.s;
    req_sub <= r.u;
    req_data <= r.d;
    @(posedge pclk);
    req_valid <= 1'b0;
    @(posedge pclk);
    chk(32'({req_done, req_ok}), 32'({1'b1, r.ok}), "request answer");
  endtask
  // waits at most the pin delay for the status byte
  task automatic settle(input logic [7:0] exp);
    int n;
    n = 0;
    while (status !== exp && n < prot_pkg::PROTECT_ASSERT_DELAY_CYCLES) begin
      @(posedge pclk);
      n++;
    end
    chk(32'(status), 32'(exp), "status");
    chk(32'(protect_on), 32'(exp[prot_pkg::STATUS_PROTECT_BIT]), "protect level");
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    #100000;
    n_mismatch++;
    report_and_stop;
  end
  initial begin
    rows = '{'{prot_pkg::REQ_ARRAY, 5'h01, 1'h0, 8'h00, 1'h0},
      '{prot_pkg::REQ_ARRAY, 5'h02, 1'h0, 8'h00, 1'h1},
      '{prot_pkg::REQ_ARRAY, 5'h00, 1'h0, 8'h00, 1'h0},
      '{prot_pkg::REQ_ARRAY, 5'h00, 1'h1, 8'h00, 1'h1},
      '{prot_pkg::REQ_PREG_PROGRAM, 5'h1F, 1'h0, 8'hFF, 1'h1},
      '{prot_pkg::REQ_ARRAY, 5'h1F, 1'h0, 8'h00, 1'h0},
      '{prot_pkg::REQ_ARRAY, 5'h1E, 1'h0, 8'h00, 1'h1}};
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    settle(8'h00);
    chk(32'(link.wp_n), 32'h1, "floating pin");
    apb(1'b0, 8'h0C, 32'h0);
    chk(32'({er, |rd}), 32'h2, "unmapped read");
    $display("test reset done");
    req('{prot_pkg::REQ_PREG_PROGRAM, 5'h01, 1'h0, 8'hFF, 1'h1});
    req('{prot_pkg::REQ_PREG_PROGRAM, 5'h00, 1'h0, 8'hC0, 1'h1});
    req('{prot_pkg::REQ_ARRAY, 5'h01, 1'h0, 8'h00, 1'h1});
    cmd(32'h1);
    settle(8'h03);
    foreach (rows[i]) req(rows[i]);
    $display("test software enable done");
    cmd(32'h2);
    settle(8'h00);
    apb(1'b1, prot_pkg::REG_CTRL, 32'h1);
    settle(8'h06);
    apb(1'b0, prot_pkg::REG_CTRL, 32'h0);
    chk(rd, 32'h1 << prot_pkg::CTRL_WP_BIT, "ctrl readback");
    apb(1'b0, prot_pkg::REG_STATUS, 32'h0);
    chk(rd, 32'h1 << prot_pkg::HSTAT_WP_BIT, "host pin status");
    req('{prot_pkg::REQ_PREG_PROGRAM, 5'h02, 1'h0, 8'hFF, 1'h0});
    req('{prot_pkg::REQ_PREG_ERASE, 5'h00, 1'h0, 8'h00, 1'h0});
    req('{prot_pkg::REQ_ARRAY, 5'h01, 1'h0, 8'h00, 1'h0});
    req('{prot_pkg::REQ_ARRAY, 5'h02, 1'h0, 8'h00, 1'h1});
    cmd(32'h1);
    settle(8'h07);
    cmd(32'h2);
    settle(8'h07);
    apb(1'b1, prot_pkg::REG_CTRL, 32'h0);
    settle(8'h03);
    cmd(32'h2);
    settle(8'h00);
    apb(1'b1, prot_pkg::REG_CTRL, 32'h1);
    settle(8'h06);
    apb(1'b1, prot_pkg::REG_CTRL, 32'h0);
    settle(8'h00);
    $display("test pin done");
    apb(1'b1, prot_pkg::REG_CTRL, 32'h1);
    apb(1'b1, prot_pkg::REG_CTRL, 32'h0);
    seen = 1'b0;
    repeat (30) begin
      @(posedge pclk);
      seen = seen | protect_on;
    end
    chk(32'(seen), 32'h0, "short pin pulse");
    $display("test glitch done");
    req('{prot_pkg::REQ_PREG_ERASE, 5'h00, 1'h0, 8'h00, 1'h1});
    cmd(32'h1);
    settle(8'h03);
    req('{prot_pkg::REQ_ARRAY, 5'h02, 1'h0, 8'h00, 1'h0});
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    settle(8'h00);
    cmd(32'h1);
    settle(8'h03);
    $display("test erase and reset done");
    report_and_stop;
  end
endmodule // flash_sector_protection_ctrl_bench
`default_nettype wire
